// ---- src/xtock_top.sv ----
/*
  Digital side of the crystal oscillator unit: host clock and reset release,
  base and bit-check clocks, synthesizer frequency word and carrier ratio,
  plus a small register port for software.
  Assumes ref_clk is the crystal oscillator clock itself; oscillator-ok, supply-ok
  and the band pin arrive asynchronously from analog circuitry.
*/
`timescale 1ns/1ps
`include "xtock_regs.svh"

module xtock_top import xtock_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic osc_amplitude_ok,
  input wire logic supply_output_ok,
  input wire logic band_pin_select,
  input wire logic low_power_mode,
  output logic host_clk,
  output logic host_rst_n,
  output logic load_cap_reduce,
  output logic base_digital_clock,
  output logic bitcheck_clock,
  output logic [11:0] synth_word_a,
  output logic [21:0] carrier_ratio,
  output logic [1:0] band_select
);

  // ----------------------------------------------------------------------------
  // Start-up sequencing states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    XTOCK_ST_HOLD,
    XTOCK_ST_RUN
  } xtock_state_e;

  xtock_state_e state_q;
  xtock_state_e state_d;

  // Pin synchronisers: stage one feeds stage two only
  logic [2:0] pin_async;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic osc_ok;
  logic supply_ok;
  logic band_pin;

  // Software registers
  logic clk_en_q;
  logic clk_en_d;
  logic band_315_select_q;
  logic band_315_select_d;
  logic [1:0] bitrate_range_q;
  logic [1:0] bitrate_range_d;
  logic [3:0] tune_hi_q;
  logic [3:0] tune_hi_d;
  logic [4:0] tune_lo_q;
  logic [4:0] tune_lo_d;
  logic [7:0] bit_period_multiplier_q;
  logic [7:0] bit_period_multiplier_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Derived outputs, all registered
  logic host_rst_n_q;
  logic host_rst_n_d;
  logic load_cap_q;
  logic load_cap_d;
  logic [11:0] word_q;
  logic [11:0] word_d;
  logic [21:0] ratio_q;
  logic [21:0] ratio_d;
  logic [1:0] band_q;
  logic [1:0] band_d;

  // Combinational helpers
  logic [8:0] synth_word_a_tune_bits;
  logic [11:0] synth_word_a_word_part_a;
  logic [11:0] synth_word_a_word_part_b;
  logic run;
  logic clk_gate;
  logic base_tick;
  logic bit_tick;

  // Decode used for the write path only; read-back decodes the address with a case
  function automatic logic addr_hit(input logic [2:0] addr, input logic [2:0] target);
    addr_hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  assign pin_async = {band_pin_select, supply_output_ok, osc_amplitude_ok};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_async[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign osc_ok = sync2_q[0];
  assign supply_ok = sync2_q[1];
  assign band_pin = sync2_q[2];

  // ----------------------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------------------
  // Running needs both good amplitude and good supply; losing either drops back
  always_comb begin
    state_d = state_q;
    case (state_q)
      XTOCK_ST_HOLD: begin
        if (osc_ok && supply_ok) begin
          state_d = XTOCK_ST_RUN;
        end
      end
      XTOCK_ST_RUN: begin
        if (!osc_ok || !supply_ok) begin
          state_d = XTOCK_ST_HOLD;
        end
      end
      default: begin
        state_d = XTOCK_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= XTOCK_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Dividers only count once the oscillator amplitude is qualified
  assign run = (state_q == XTOCK_ST_RUN);
  // Gating is synchronous here, and the divider starts from phase zero, so the host's first edge is aligned
  assign clk_gate = run && clk_en_q;

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always_comb begin
    clk_en_d = clk_en_q;
    band_315_select_d = band_315_select_q;
    bitrate_range_d = bitrate_range_q;
    tune_hi_d = tune_hi_q;
    tune_lo_d = tune_lo_q;
    bit_period_multiplier_d = bit_period_multiplier_q;
    if (reg_wr) begin
      if (addr_hit(reg_addr, `XTOCK_ADDR_CTRL)) begin
        clk_en_d = reg_wdata[`XTOCK_CTRL_CLK_EN];
        band_315_select_d = reg_wdata[`XTOCK_CTRL_FS];
        bitrate_range_d = reg_wdata[`XTOCK_CTRL_BR_MSB:`XTOCK_CTRL_BR_LSB];
      end
      if (addr_hit(reg_addr, `XTOCK_ADDR_TUNE_HI)) begin
        tune_hi_d = reg_wdata[`XTOCK_TUNE_HI_W-1:0];
      end
      if (addr_hit(reg_addr, `XTOCK_ADDR_TUNE_LO)) begin
        tune_lo_d = reg_wdata[`XTOCK_TUNE_LO_W-1:0];
      end
      if (addr_hit(reg_addr, `XTOCK_ADDR_MULT)) begin
        bit_period_multiplier_d = reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_q <= 1'(`XTOCK_RST_CTRL >> `XTOCK_CTRL_CLK_EN);
      band_315_select_q <= 1'b0;
      bitrate_range_q <= 2'h0;
      tune_hi_q <= `XTOCK_RST_TUNE_HI;
      tune_lo_q <= `XTOCK_RST_TUNE_LO;
      bit_period_multiplier_q <= `XTOCK_RST_MULT;
    end else begin
      clk_en_q <= clk_en_d;
      band_315_select_q <= band_315_select_d;
      bitrate_range_q <= bitrate_range_d;
      tune_hi_q <= tune_hi_d;
      tune_lo_q <= tune_lo_d;
      bit_period_multiplier_q <= bit_period_multiplier_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Frequency word and carrier ratio
  // ----------------------------------------------------------------------------
  // Upper four tuning bits weigh 32 each, lower five weigh one each
  assign synth_word_a_tune_bits = {tune_hi_q, tune_lo_q};
  assign synth_word_a_word_part_a = {3'h0, tune_hi_q, 5'h00};
  assign synth_word_a_word_part_b = {7'h00, tune_lo_q};

  // Ratio is carrier over crystal in units of 1/32768, so the half-steps stay exact.
  // No range check: words outside the quiet window are the host's concern.
  always_comb begin
    word_d = `XTOCK_SYNTH_WORD_A_BASE + synth_word_a_word_part_a + synth_word_a_word_part_b;
    if (band_315_select_q) begin
      band_d = XTOCK_BAND_315;
      ratio_d = `XTOCK_N315_X2_SHIFTED;
    end else if (band_pin) begin
      band_d = XTOCK_BAND_433;
      ratio_d = `XTOCK_N433_X2_SHIFTED;
    end else begin
      band_d = XTOCK_BAND_868;
      ratio_d = `XTOCK_N868_X2_SHIFTED;
    end
    ratio_d = ratio_d + {9'h000, word_d, 1'b0} + `XTOCK_SYNTH_WORD_A_OFFSET_X2;
  end

  // ----------------------------------------------------------------------------
  // Host reset, load capacitors and read-back
  // ----------------------------------------------------------------------------
  always_comb begin
    host_rst_n_d = run;
    load_cap_d = low_power_mode;
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `XTOCK_ADDR_CTRL: begin
          rdata_d = {4'h0, bitrate_range_q, band_315_select_q, clk_en_q};
        end
        `XTOCK_ADDR_TUNE_HI: begin
          rdata_d = {4'h0, synth_word_a_tune_bits[8:5]};
        end
        `XTOCK_ADDR_TUNE_LO: begin
          rdata_d = {3'h0, synth_word_a_tune_bits[4:0]};
        end
        `XTOCK_ADDR_MULT: begin
          rdata_d = bit_period_multiplier_q;
        end
        `XTOCK_ADDR_STATUS: begin
          rdata_d = {3'h0, clk_gate, band_pin, host_rst_n_q, supply_ok, osc_ok};
        end
        `XTOCK_ADDR_WORD_LO: begin
          rdata_d = word_q[7:0];
        end
        `XTOCK_ADDR_WORD_HI: begin
          rdata_d = {4'h0, word_q[11:8]};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rst_n_q <= 1'b0;
      load_cap_q <= 1'b0;
      word_q <= `XTOCK_SYNTH_WORD_A_BASE;
      ratio_q <= `XTOCK_N868_X2_SHIFTED;
      band_q <= XTOCK_BAND_868;
      rdata_q <= 8'h00;
    end else begin
      host_rst_n_q <= host_rst_n_d;
      load_cap_q <= load_cap_d;
      word_q <= word_d;
      ratio_q <= ratio_d;
      band_q <= band_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------------------
  xtock_host_clk_div u_host_clk (
    .clk(ref_clk),
    .rst_n(rst_n),
    .enable(clk_gate),
    .host_clk(host_clk)
  );

  // Bit-check clock drives polling and transmit bit timing elsewhere in the chip
  xtock_bit_timer u_bit_timer (
    .clk(ref_clk),
    .rst_n(rst_n),
    .run(run),
    .bitrate_range(bitrate_range_q),
    .bit_period_multiplier(bit_period_multiplier_q),
    .base_tick(base_tick),
    .bit_tick(bit_tick)
  );

  assign base_digital_clock = base_tick;
  assign bitcheck_clock = bit_tick;
  assign host_rst_n = host_rst_n_q;
  assign load_cap_reduce = load_cap_q;
  assign synth_word_a = word_q;
  assign carrier_ratio = ratio_q;
  assign band_select = band_q;
  assign reg_rdata = rdata_q;

endmodule

// ---- include/xtock_regs.svh ----
/*
  Register offsets, field positions, reset values and fixed counts of the crystal
  clock divider and frequency word block.
  Assumes it is included by bare name and holds definitions only.
*/
`ifndef XTOCK_REGS_SVH
`define XTOCK_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (3-bit address, 8-bit data)
// ----------------------------------------------------------------------------
`define XTOCK_ADDR_CTRL 3'h0
`define XTOCK_ADDR_TUNE_HI 3'h1
`define XTOCK_ADDR_TUNE_LO 3'h2
`define XTOCK_ADDR_MULT 3'h3
`define XTOCK_ADDR_STATUS 3'h4
`define XTOCK_ADDR_WORD_LO 3'h5
`define XTOCK_ADDR_WORD_HI 3'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define XTOCK_CTRL_CLK_EN 0
`define XTOCK_CTRL_FS 1
`define XTOCK_CTRL_BR_LSB 2
`define XTOCK_CTRL_BR_MSB 3
`define XTOCK_TUNE_HI_W 4
`define XTOCK_TUNE_LO_W 5
`define XTOCK_STAT_OSC_OK 0
`define XTOCK_STAT_SUPPLY_OK 1
`define XTOCK_STAT_RST_REL 2
`define XTOCK_STAT_BAND_PIN 3
`define XTOCK_STAT_CLK_RUN 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define XTOCK_RST_CTRL 8'h00
`define XTOCK_RST_TUNE_HI 4'h0
`define XTOCK_RST_TUNE_LO 5'h00
`define XTOCK_RST_MULT 8'h01

// ----------------------------------------------------------------------------
// Fixed counts and arithmetic constants
// ----------------------------------------------------------------------------
`define XTOCK_HOST_DIV 2'h3
`define XTOCK_BASE_DIV_LAST 4'hf
`define XTOCK_SYNTH_WORD_A_BASE 12'he00
`define XTOCK_SYNTH_WORD_A_OFFSET_X2 22'h000029
`define XTOCK_N433_X2_SHIFTED 22'h104000
`define XTOCK_N868_X2_SHIFTED 22'h204000
`define XTOCK_N315_X2_SHIFTED 22'h0c4000

`endif

// ---- include/xtock_pkg.sv ----
/*
  Types shared by the crystal clock divider and frequency word block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package xtock_pkg;

  // Carrier band selected by the band pin and the 315 select bit
  typedef enum logic [1:0] {
    XTOCK_BAND_433,
    XTOCK_BAND_868,
    XTOCK_BAND_315
  } xtock_band_e;

  typedef logic [11:0] xtock_word_t;

endpackage

// ---- src/xtock_host_clk_div.sv ----
/*
  Divide-by-three host clock generator with equal high and low phases.
  Assumes clk is the crystal clock and enable is synchronous to it.
*/
`timescale 1ns/1ps
`include "xtock_regs.svh"

module xtock_host_clk_div import xtock_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  output logic host_clk
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;

  // ----------------------------------------------------------------------------
  // Counter and rising-phase flop
  // ----------------------------------------------------------------------------
  // Held at phase zero while disabled so the first cycle starts cleanly
  always_comb begin
    if (!enable) begin
      cnt_d = 2'h0;
    end else if (cnt_q == (`XTOCK_HOST_DIV - 2'h1)) begin
      cnt_d = 2'h0;
    end else begin
      cnt_d = cnt_q + 2'h1;
    end
    rise_d = enable && (cnt_d == 2'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      rise_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rise_q <= rise_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Half-period delayed copy
  // ----------------------------------------------------------------------------
  // An odd ratio cannot give 50% from one edge; the falling-edge copy adds half a cycle
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_q <= 1'b0;
    end else begin
      fall_q <= rise_q;
    end
  end

  // High for 1.5 crystal periods, low for 1.5
  assign host_clk = rise_q | fall_q;

endmodule

// ---- src/xtock_bit_timer.sv ----
/*
  Base digital clock (crystal / 16) and bit-check clock generator.
  Assumes run is synchronous to clk; ticks are one-cycle pulses.
*/
`timescale 1ns/1ps
`include "xtock_regs.svh"

module xtock_bit_timer import xtock_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] bitrate_range,
  input wire logic [7:0] bit_period_multiplier,
  output logic base_tick,
  output logic bit_tick
);

  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [10:0] bit_cnt_q;
  logic [10:0] bit_cnt_d;
  logic base_q;
  logic base_d;
  logic bit_q;
  logic bit_d;
  logic [10:0] bit_last;

  // Base periods per bit-check period, minus one; a zero multiplier acts as one
  function automatic logic [10:0] period_last(input logic [1:0] range,
                                              input logic [7:0] mult);
    logic [7:0] m;
    logic [10:0] scaled;
    m = (mult == 8'h00) ? 8'h01 : mult;
    case (range)
      2'h0: scaled = {m, 3'h0};
      2'h1: scaled = {1'b0, m, 2'h0};
      2'h2: scaled = {2'h0, m, 1'b0};
      default: scaled = {3'h0, m};
    endcase
    period_last = scaled - 11'h001;
  endfunction

  assign bit_last = period_last(bitrate_range, bit_period_multiplier);

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Both counters sit at zero until run, so derived clocks start at a known phase
  always_comb begin
    pre_d = 4'h0;
    bit_cnt_d = bit_cnt_q;
    base_d = 1'b0;
    bit_d = 1'b0;
    if (!run) begin
      bit_cnt_d = 11'h000;
    end else begin
      pre_d = pre_q + 4'h1;
      if (pre_q == `XTOCK_BASE_DIV_LAST) begin
        base_d = 1'b1;
        if (bit_cnt_q >= bit_last) begin
          bit_cnt_d = 11'h000;
          bit_d = 1'b1;
        end else begin
          bit_cnt_d = bit_cnt_q + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
      bit_cnt_q <= 11'h000;
      base_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      bit_cnt_q <= bit_cnt_d;
      base_q <= base_d;
      bit_q <= bit_d;
    end
  end

  assign base_tick = base_q;
  assign bit_tick = bit_q;

endmodule

// ---- tb/xtock_props.sv ----
/*
  Concurrent checks on the ports of the clock divider and frequency word top.
  Assumes it is bound into xtock_top and that ref_clk is the only clock.
*/
`timescale 1ns/1ps
`include "xtock_regs.svh"

module xtock_props import xtock_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_amplitude_ok,
  input wire logic supply_output_ok,
  input wire logic low_power_mode,
  input wire logic host_clk,
  input wire logic host_rst_n,
  input wire logic load_cap_reduce,
  input wire logic base_digital_clock,
  input wire logic bitcheck_clock,
  input wire logic [11:0] synth_word_a,
  input wire logic [21:0] carrier_ratio,
  input wire logic [1:0] band_select
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic [5:0] ok_cnt_q, ok_cnt_d, quiet_q, quiet_d;
  logic [21:0] nterm;

  // Both counters saturate, so a long run never wraps them into a false window
  always_comb begin
    ok_cnt_d = ok_cnt_q + 6'h01;
    if (ok_cnt_q == 6'h3f) ok_cnt_d = ok_cnt_q;
    if (!(osc_amplitude_ok && supply_output_ok)) ok_cnt_d = 6'h00;
    quiet_d = quiet_q + 6'h01;
    if (quiet_q == 6'h3f) quiet_d = quiet_q;
    if (reg_wr) quiet_d = 6'h00;
    nterm = `XTOCK_N868_X2_SHIFTED;
    if (band_select == 2'h0) nterm = `XTOCK_N433_X2_SHIFTED;
    if (band_select == 2'h2) nterm = `XTOCK_N315_X2_SHIFTED;
  end

  // Counters restart on reset so no check gated by them opens straight after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_cnt_q <= 6'h00;
      quiet_q <= 6'h00;
    end else begin
      ok_cnt_q <= ok_cnt_d;
      quiet_q <= quiet_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_base_gap;
    !base_digital_clock[*8] ##1 !base_digital_clock[*7];
  endsequence

  chk_base_gap: assert property (base_digital_clock && ok_cnt_q > 6'd30 |=>
    s_base_gap ##1 (base_digital_clock || ok_cnt_q < 6'd20))
    else $error("base tick spacing is not 16 cycles");
  chk_host_div: assert property (ok_cnt_q > 6'd30 && quiet_q > 6'd8 |->
    host_clk == $past(host_clk, 3)) else $error("host clock period is not 3 cycles");
  chk_gate_off: assert property ((!osc_amplitude_ok)[*6] |->
    !host_clk && !base_digital_clock && !bitcheck_clock && !host_rst_n)
    else $error("dividers run without oscillator ok");
  chk_rst_supply: assert property ((!supply_output_ok)[*6] |-> !host_rst_n)
    else $error("host reset released with supply low");
  chk_rst_early: assert property ($rose(host_rst_n) |-> ok_cnt_q >= 6'd2)
    else $error("host reset released too early");
  chk_rst_prompt: assert property (ok_cnt_q == 6'd12 |-> host_rst_n)
    else $error("host reset not released");
  chk_bit_on_base: assert property (bitcheck_clock |-> base_digital_clock)
    else $error("bit tick away from base tick");
  chk_word_write: assert property (reg_wr && reg_addr == `XTOCK_ADDR_TUNE_LO |->
    ##2 synth_word_a[4:0] == $past(reg_wdata[4:0], 2)) else $error("word low part wrong");
  chk_word_base: assert property (synth_word_a[11:9] == 3'h7)
    else $error("word below its base");
  chk_ratio_calc: assert property (quiet_q > 6'd4 && $past(band_select, 2) == band_select
    && $past(synth_word_a, 2) == synth_word_a |->
    carrier_ratio == nterm + {9'h000, synth_word_a, 1'b0} + `XTOCK_SYNTH_WORD_A_OFFSET_X2)
    else $error("carrier ratio wrong");
  chk_cap_follow: assert property (low_power_mode |=> load_cap_reduce)
    else $error("load capacitors not reduced");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind xtock_top xtock_props u_props (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .osc_amplitude_ok, .supply_output_ok, .low_power_mode, .host_clk,
  .host_rst_n, .load_cap_reduce, .base_digital_clock, .bitcheck_clock, .synth_word_a,
  .carrier_ratio, .band_select);

// ---- tb/xtock_host_model.sv ----
/*
  Behavioural host microcontroller that is clocked and reset by the block.
  Assumes host_clk and host_rst_n come straight from the block.
*/
`timescale 1ns/1ps

module xtock_host_model (
  input wire logic host_clk,
  input wire logic host_rst_n,
  output logic [31:0] period_ps,
  output logic [31:0] high_ps,
  output logic [7:0] n_edges
);
  realtime t_rise;

  initial begin
    period_ps = '0;
    high_ps = '0;
    n_edges = '0;
    t_rise = 0;
  end

  // Measures by edge time; the first period is never trusted, it may be short
  always @(posedge host_clk) begin
    if (n_edges != 8'h00) period_ps = int'(($realtime - t_rise) * 1000.0);
    t_rise = $realtime;
    if (!host_rst_n) n_edges = 8'h00;
    else if (n_edges != 8'hff) n_edges = n_edges + 8'h01;
  end

  // High phase length, from the last rise
  always @(negedge host_clk) begin
    if (n_edges != 8'h00) high_ps = int'(($realtime - t_rise) * 1000.0);
  end
endmodule

// ---- tb/xtock_bench.sv ----
/*
  Self-checking bench for the clock divider and frequency word top.
  Assumes the props checker is bound in and the host model stands on host_clk.
*/
`timescale 1ns/1ps
`include "xtock_regs.svh"

module xtock_bench import xtock_pkg::*;;
  logic ref_clk, rst_n, reg_wr, reg_rd, osc_amplitude_ok, supply_output_ok;
  logic band_pin_select, low_power_mode, host_clk, host_rst_n, load_cap_reduce;
  logic base_digital_clock, bitcheck_clock;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, n_edges, rv;
  logic [11:0] synth_word_a;
  logic [21:0] carrier_ratio;
  logic [1:0] band_select;
  logic [31:0] period_ps, high_ps;
  int n_errors, check_count, n, k;

  xtock_top DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .osc_amplitude_ok, .supply_output_ok, .band_pin_select, .low_power_mode, .host_clk,
    .host_rst_n, .load_cap_reduce, .base_digital_clock, .bitcheck_clock, .synth_word_a,
    .carrier_ratio, .band_select);
  xtock_host_model u_host (.host_clk, .host_rst_n, .period_ps, .high_ps, .n_edges);

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // Cycles between two ticks of the base (sel 0) or bit-check (sel 1) output
  task automatic gap(input logic sel, output int g);
    int w;
    w = 0;
    g = 1;
    // Step off the edge first so a tick launched on it is not read stale
    #1;
    while ((sel ? bitcheck_clock : base_digital_clock) !== 1'b1 && w < 2000) begin
      @(posedge ref_clk); #1 w++;
    end
    @(posedge ref_clk); #1;
    while ((sel ? bitcheck_clock : base_digital_clock) !== 1'b1 && g < 2000) begin
      @(posedge ref_clk); #1 g++;
    end
  endtask

  task automatic t_band(input logic pin, input logic fs, input logic [1:0] b,
                        input logic [21:0] nt, input logic [11:0] w);
    @(posedge ref_clk);
    band_pin_select <= pin;
    wr(`XTOCK_ADDR_CTRL, {6'h00, fs, 1'b1});
    repeat (6) @(posedge ref_clk);
    #1 check(band_select, b);
    check(carrier_ratio, nt + {9'h000, w, 1'b0} + `XTOCK_SYNTH_WORD_A_OFFSET_X2);
  endtask

  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Before the oscillator is good: reset values, no clocks, unmapped read
  task automatic t_idle;
    repeat (4) @(posedge ref_clk);
    #1 check(synth_word_a, 12'he00);
    check(host_rst_n, 1'b0);
    rd(`XTOCK_ADDR_MULT, rv);
    check(rv, 8'h01);
    rd(3'h7, rv);
    check(rv, 8'h00);
    check(base_digital_clock, 1'b0);
  endtask

  // Supply alone must not release the host; oscillator ok then does, promptly
  task automatic t_release;
    @(posedge ref_clk);
    supply_output_ok <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 check(host_rst_n, 1'b0);
    @(posedge ref_clk);
    osc_amplitude_ok <= 1'b1;
    k = 0;
    while (host_rst_n !== 1'b1 && k < 12) begin
      @(posedge ref_clk); #1 k++;
    end
    check(host_rst_n, 1'b1);
    rd(`XTOCK_ADDR_STATUS, rv);
    check(rv, 8'h0f);
  endtask

  // Host clock frequency and duty, then base and bit-check spacing per range
  task automatic t_clocks;
    wr(`XTOCK_ADDR_CTRL, 8'h01);
    k = 0;
    while (n_edges < 8'd4 && k < 500) begin
      @(posedge ref_clk); k++;
    end
    check(period_ps, 32'd30000);
    check(high_ps, 32'd15000);
    rd(`XTOCK_ADDR_STATUS, rv);
    check(rv, 8'h1f);
    gap(1'b0, n);
    check(n, 16);
    wr(`XTOCK_ADDR_MULT, 8'h03);
    for (int r = 0; r < 4; r++) begin
      wr(`XTOCK_ADDR_CTRL, {4'h0, r[1:0], 2'b01});
      gap(1'b1, n);
      gap(1'b1, n);
      check(n, 48 << (3 - r));
    end
  endtask

  // Tuning words at both ends of the allowed span, with junk above each field
  task automatic t_words;
    logic [3:0] hi [3] = '{4'h6, 4'h9, 4'he};
    logic [4:0] lo [3] = '{5'h1b, 5'h1c, 5'h15};
    logic [11:0] w;
    for (int i = 0; i < 3; i++) begin
      w = 12'he00 + {3'h0, hi[i], lo[i]};
      wr(`XTOCK_ADDR_TUNE_HI, {4'hf, hi[i]});
      wr(`XTOCK_ADDR_TUNE_LO, {3'h7, lo[i]});
      repeat (3) @(posedge ref_clk);
      #1 check(synth_word_a, w);
      rd(`XTOCK_ADDR_WORD_LO, rv);
      check(rv, w[7:0]);
      rd(`XTOCK_ADDR_WORD_HI, rv);
      check(rv, {4'h0, w[11:8]});
      rd(`XTOCK_ADDR_TUNE_HI, rv);
      check(rv, {4'h0, hi[i]});
      t_band(1'b1, 1'b0, 2'h0, `XTOCK_N433_X2_SHIFTED, w);
      t_band(1'b0, 1'b0, 2'h1, `XTOCK_N868_X2_SHIFTED, w);
      t_band(1'b1, 1'b1, 2'h2, `XTOCK_N315_X2_SHIFTED, w);
    end
  endtask

  task automatic t_lowpow;
    @(posedge ref_clk);
    low_power_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check(load_cap_reduce, 1'b1);
    @(posedge ref_clk);
    low_power_mode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(load_cap_reduce, 1'b0);
  endtask

  // Losing the oscillator stops every divider and pulls host reset
  task automatic t_drop;
    @(posedge ref_clk);
    osc_amplitude_ok <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 check(host_rst_n, 1'b0);
    n = 0;
    for (int c = 0; c < 40; c++) begin
      @(posedge ref_clk); #1 n += int'(base_digital_clock | host_clk);
    end
    check(n, 0);
  endtask

  // ----------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, osc_amplitude_ok, supply_output_ok, low_power_mode} = '0;
    band_pin_select = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_idle();
    t_release();
    t_clocks();
    t_words();
    t_lowpow();
    t_drop();
    final_report();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end
endmodule
